/* File: ifd_addr_adder.v */
/*
 Operand address adder: displacement plus base, index and relocation.
 Assumes operand values arrive stable within one cycle; purely
 combinational, the caller registers the sum.
*/
`timescale 1ns/1ps
`include "ifd_consts.vh"

module ifd_addr_adder #(
  parameter AW = 24
) (
  input wire [11:0] disp_in,
  input wire [31:0] base_data_in,
  input wire [31:0] index_data_in,
  input wire base_zero_in,
  input wire index_zero_in,
  input wire [11:0] reloc_in,
  input wire reloc_en_in,
  output wire [AW-1:0] sum_out
);

  wire [AW-1:0] base_val;
  wire [AW-1:0] index_val;
  wire [AW-1:0] reloc_val;
  wire [AW-1:0] disp_val;

  assign base_val = base_zero_in ? {AW{1'b0}} : base_data_in[AW-1:0];
  assign index_val = index_zero_in ? {AW{1'b0}} : index_data_in[AW-1:0];
  assign reloc_val = reloc_en_in ? {{(AW-12){1'b0}}, reloc_in}
                                 : {AW{1'b0}};
  assign disp_val = {{(AW-12){1'b0}}, disp_in};
  assign sum_out = disp_val + base_val + index_val + reloc_val;

endmodule // ifd_addr_adder

/* File: ifd_consts.vh */
/*
 Field positions, format codes and half word counts for the instruction
 format decoder. Assumes instructions arrive left-justified in a
 48-bit word, instruction bit 0 being word bit 47.
*/
`ifndef IFD_CONSTS_VH
`define IFD_CONSTS_VH

// Field positions in the 48-bit left-justified word
`define IFD_OP_HI 47
`define IFD_OP_LO 40
`define IFD_R1_HI 39
`define IFD_R1_LO 36
`define IFD_R2_HI 35
`define IFD_R2_LO 32
`define IFD_B_HI 31
`define IFD_B_LO 28
`define IFD_D_HI 27
`define IFD_D_LO 16
`define IFD_SSB2_HI 15
`define IFD_SSB2_LO 12
`define IFD_SSD2_HI 11
`define IFD_SSD2_LO 0

// Op code class bits and the index into class masks
`define IFD_CLASS_HI 7
`define IFD_CLASS_LO 6
`define IFD_SUB_HI 5
`define IFD_SUB_LO 0
`define IFD_CLASS_RR 2'h0
`define IFD_CLASS_RX 2'h1
`define IFD_CLASS_RS_SI 2'h2

// Format codes
`define IFD_FMT_RR 3'h0
`define IFD_FMT_RX 3'h1
`define IFD_FMT_RS 3'h2
`define IFD_FMT_SI 3'h3
`define IFD_FMT_SS 3'h4

// Half word counts per format
`define IFD_HW_ONE 2'h1
`define IFD_HW_TWO 2'h2
`define IFD_HW_THREE 2'h3

// Relocation offset position in the relocation register
`define IFD_RELOC_HI 11
`define IFD_RELOC_LO 0

// Register number meaning a zero base or index
`define IFD_REG_ZERO 4'h0

`endif

/* File: ifd_decoder.v */
/*
 Instruction format decoder: splits fields, checks privilege, sizes
 the instruction, forms operand addresses and walks variable-length
 operands byte by byte. Assumes the register file answers base and
 index contents combinationally during the cycle dec_valid_out is high,
 and that fetch holds further instructions while busy_out is high.
*/
`timescale 1ns/1ps
`include "ifd_consts.vh"

//////////////////////////////////////////////////////////////////////
module ifd_decoder #(
  parameter AW = 24,
  parameter [255:0] PRIV_OPS = 256'h0,
  parameter [63:0] SI_OPS = 64'h0,
  parameter [63:0] IMM_RR_OPS = 64'h0,
  parameter [63:0] FPR_OPS = 64'h0,
  parameter [7:0] BCR_OP = 8'h07,
  parameter [7:0] LA_OP = 8'h41
) (
  input wire ref_clk_in,
  input wire rst_in,
  input wire instr_valid_in,
  input wire [47:0] instr_in,
  input wire [AW-1:0] instr_addr_in,
  input wire supervisor_in,
  input wire [19:0] reloc_reg_in,
  input wire reloc_en_in,
  input wire [31:0] base_data_in,
  input wire [31:0] index_data_in,
  output reg busy_out,
  output reg dec_valid_out,
  output reg [7:0] opcode_out,
  output reg [2:0] format_out,
  output reg [1:0] halfwords_out,
  output reg [AW-1:0] next_fetch_addr_out,
  output reg fetch_align_err_out,
  output reg priv_exc_out,
  output reg [3:0] first_operand_reg_out,
  output reg [3:0] second_operand_reg_out,
  output reg fpr_sel_out,
  output reg [3:0] branch_mask_field_out,
  output reg mask_valid_out,
  output reg [7:0] immediate_byte_field_out,
  output reg imm_valid_out,
  output reg [3:0] index_reg_field_out,
  output reg [3:0] base_reg_field_out,
  output reg [11:0] displacement_field_out,
  output reg [3:0] result_reg_out,
  output reg result_valid_out,
  output reg addr_valid_out,
  output reg [AW-1:0] addr_out,
  output reg mem_access_out,
  output reg la_write_out,
  output reg [3:0] la_reg_out,
  output reg [31:0] la_data_out,
  output reg byte_valid_out,
  output reg [AW-1:0] byte_addr_out,
  output reg byte_last_out,
  output reg [8:0] oper_len_out
);

  localparam ST_IDLE = 2'h0;
  localparam ST_ADDR = 2'h1;
  localparam ST_WALK = 2'h2;

  //////////////////////////////////////////////////////////////////////
  // Decode functions

  function [2:0] ifd_fmt;
    input [7:0] op;
    begin
      case (op[`IFD_CLASS_HI:`IFD_CLASS_LO])
        `IFD_CLASS_RR: ifd_fmt = `IFD_FMT_RR;
        `IFD_CLASS_RX: ifd_fmt = `IFD_FMT_RX;
        `IFD_CLASS_RS_SI:
          ifd_fmt = SI_OPS[op[`IFD_SUB_HI:`IFD_SUB_LO]] ? `IFD_FMT_SI
                                                      : `IFD_FMT_RS;
        default: ifd_fmt = `IFD_FMT_SS;
      endcase
    end
  endfunction

  function [1:0] ifd_hw;
    input [2:0] fmt;
    begin
      case (fmt)
        `IFD_FMT_RR: ifd_hw = `IFD_HW_ONE;
        `IFD_FMT_SS: ifd_hw = `IFD_HW_THREE;
        default: ifd_hw = `IFD_HW_TWO;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Field split

  wire [7:0] op_w;
  wire [2:0] fmt_w;
  wire [1:0] hw_w;
  wire accept_w;
  wire priv_ok_w;
  wire [AW-1:0] sum_w;
  wire [AW-1:0] fetch_base_w;
  wire is_rr_w;

  assign op_w = instr_in[`IFD_OP_HI:`IFD_OP_LO];
  assign fmt_w = ifd_fmt(op_w);
  assign hw_w = ifd_hw(fmt_w);
  assign is_rr_w = (fmt_w == `IFD_FMT_RR);
  // Requests during a byte walk are ignored, not queued
  assign accept_w = instr_valid_in & ~busy_out;
  assign priv_ok_w = supervisor_in | ~PRIV_OPS[op_w];
  assign fetch_base_w = {instr_addr_in[AW-1:1], 1'b0};

  //////////////////////////////////////////////////////////////////////
  // Address adder

  reg [11:0] add_disp_reg;
  reg add_index_zero_reg;
  reg add_base_zero_reg;
  reg add_ss_reg;
  reg add_la_reg;
  reg add_mem_reg;
  reg [7:0] add_len_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;

  ifd_addr_adder #(
    .AW(AW)
  ) u_adder (
    .disp_in(add_disp_reg),
    .base_data_in(base_data_in),
    .index_data_in(index_data_in),
    .base_zero_in(add_base_zero_reg),
    .index_zero_in(add_index_zero_reg),
    .reloc_in(reloc_reg_in[`IFD_RELOC_HI:`IFD_RELOC_LO]),
    .reloc_en_in(reloc_en_in),
    .sum_out(sum_w)
  );

  //////////////////////////////////////////////////////////////////////
  // Sequencer states

  reg [7:0] walk_cnt_reg;

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (accept_w && priv_ok_w && !is_rr_w)
          state_next = ST_ADDR;
      ST_ADDR:
        state_next = add_ss_reg ? ST_WALK : ST_IDLE;
      ST_WALK:
        if (walk_cnt_reg == 8'h00)
          state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // Decode stage

  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      state_reg <= ST_IDLE;
      busy_out <= 1'b0;
      dec_valid_out <= 1'b0;
      opcode_out <= 8'h00;
      format_out <= `IFD_FMT_RR;
      halfwords_out <= 2'h0;
      next_fetch_addr_out <= {AW{1'b0}};
      fetch_align_err_out <= 1'b0;
      priv_exc_out <= 1'b0;
      first_operand_reg_out <= 4'h0;
      second_operand_reg_out <= 4'h0;
      fpr_sel_out <= 1'b0;
      branch_mask_field_out <= 4'h0;
      mask_valid_out <= 1'b0;
      immediate_byte_field_out <= 8'h00;
      imm_valid_out <= 1'b0;
      index_reg_field_out <= 4'h0;
      base_reg_field_out <= 4'h0;
      displacement_field_out <= 12'h000;
      result_reg_out <= 4'h0;
      result_valid_out <= 1'b0;
      add_disp_reg <= 12'h000;
      add_index_zero_reg <= 1'b1;
      add_base_zero_reg <= 1'b1;
      add_ss_reg <= 1'b0;
      add_la_reg <= 1'b0;
      add_mem_reg <= 1'b0;
      add_len_reg <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      busy_out <= (state_next != ST_IDLE);
      dec_valid_out <= accept_w & priv_ok_w;
      priv_exc_out <= accept_w & ~priv_ok_w;
      mask_valid_out <= 1'b0;
      imm_valid_out <= 1'b0;
      result_valid_out <= 1'b0;
      if (accept_w)
      begin
        opcode_out <= op_w;
        format_out <= fmt_w;
        halfwords_out <= hw_w;
        fetch_align_err_out <= instr_addr_in[0];
        next_fetch_addr_out <= fetch_base_w + {{(AW-3){1'b0}}, hw_w, 1'b0};
        first_operand_reg_out <= instr_in[`IFD_R1_HI:`IFD_R1_LO];
        second_operand_reg_out <= instr_in[`IFD_R2_HI:`IFD_R2_LO];
        index_reg_field_out <= instr_in[`IFD_R2_HI:`IFD_R2_LO];
        base_reg_field_out <= instr_in[`IFD_B_HI:`IFD_B_LO];
        displacement_field_out <= instr_in[`IFD_D_HI:`IFD_D_LO];
        branch_mask_field_out <= instr_in[`IFD_R1_HI:`IFD_R1_LO];
        immediate_byte_field_out <= instr_in[`IFD_R1_HI:`IFD_R2_LO];
        fpr_sel_out <= (fmt_w == `IFD_FMT_RR || fmt_w == `IFD_FMT_RX) &&
                       FPR_OPS[op_w[`IFD_SUB_HI:`IFD_SUB_LO]];
        // branch mask only for this op
        mask_valid_out <= priv_ok_w && is_rr_w && (op_w == BCR_OP);
        imm_valid_out <= priv_ok_w && is_rr_w &&
                         IMM_RR_OPS[op_w[`IFD_SUB_HI:`IFD_SUB_LO]];
        result_reg_out <= instr_in[`IFD_R1_HI:`IFD_R1_LO];
        result_valid_out <= priv_ok_w && (fmt_w == `IFD_FMT_RX);
        add_disp_reg <= instr_in[`IFD_D_HI:`IFD_D_LO];
        add_base_zero_reg <=
          (instr_in[`IFD_B_HI:`IFD_B_LO] == `IFD_REG_ZERO);
        // Only the indexed format carries an index term
        add_index_zero_reg <= (fmt_w != `IFD_FMT_RX) ||
          (instr_in[`IFD_R2_HI:`IFD_R2_LO] == `IFD_REG_ZERO);
        add_ss_reg <= (fmt_w == `IFD_FMT_SS);
        add_la_reg <= (op_w == LA_OP);
        add_mem_reg <= (op_w != LA_OP);
        add_len_reg <= instr_in[`IFD_R1_HI:`IFD_R2_LO];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Address stage

  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      addr_valid_out <= 1'b0;
      addr_out <= {AW{1'b0}};
      mem_access_out <= 1'b0;
      la_write_out <= 1'b0;
      la_reg_out <= 4'h0;
      la_data_out <= 32'h00000000;
      oper_len_out <= 9'h000;
    end
    else
    begin
      addr_valid_out <= (state_reg == ST_ADDR);
      mem_access_out <= (state_reg == ST_ADDR) & add_mem_reg;
      la_write_out <= (state_reg == ST_ADDR) & add_la_reg;
      if (state_reg == ST_ADDR)
      begin
        addr_out <= sum_w;
        la_reg_out <= first_operand_reg_out;
        la_data_out <= {{(32-AW){1'b0}}, sum_w};
        // length byte plus one, up to 256
        oper_len_out <= {1'b0, add_len_reg} + 9'h001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Variable-length byte walk

  // No alignment check: operands may start on any byte
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      walk_cnt_reg <= 8'h00;
      byte_valid_out <= 1'b0;
      byte_addr_out <= {AW{1'b0}};
      byte_last_out <= 1'b0;
    end
    else
    begin
      byte_valid_out <= (state_reg == ST_WALK);
      byte_last_out <= (state_reg == ST_WALK) && (walk_cnt_reg == 8'h00);
      if (state_reg == ST_ADDR)
      begin
        walk_cnt_reg <= add_len_reg;
        byte_addr_out <= sum_w;
      end
      else if (state_reg == ST_WALK)
      begin
        walk_cnt_reg <= walk_cnt_reg - 8'h01;
        if (byte_valid_out)
          byte_addr_out <= byte_addr_out + {{(AW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // ifd_decoder

/* File: ifd_decoder_assertions.sv */
/*
 Checker for the instruction format decoder, bound to ifd_decoder.
 Assumes the single reference clock and synchronous active-high reset.
*/
`timescale 1ns/1ps

module ifd_decoder_chk #(
  parameter AW = 24
) (
  input wire ref_clk_in,
  input wire rst_in,
  input wire instr_valid_in,
  input wire [47:0] instr_in,
  input wire [AW-1:0] instr_addr_in,
  input wire supervisor_in,
  input wire busy_out,
  input wire dec_valid_out,
  input wire [7:0] opcode_out,
  input wire [2:0] format_out,
  input wire [1:0] halfwords_out,
  input wire [AW-1:0] next_fetch_addr_out,
  input wire priv_exc_out,
  input wire [3:0] first_operand_reg_out,
  input wire [3:0] second_operand_reg_out,
  input wire addr_valid_out,
  input wire mem_access_out,
  input wire la_write_out,
  input wire byte_valid_out,
  input wire [AW-1:0] byte_addr_out,
  input wire byte_last_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  //////////////////////////////////////////////////////////////////////
  sequence s_stor_dec;
    dec_valid_out && format_out != 3'h0;
  endsequence
  sequence s_la_done;
    addr_valid_out && !mem_access_out;
  endsequence

  a_opcode_top: assert property (
    dec_valid_out |-> opcode_out == $past(instr_in[47:40]))
    else $error("opcode not top byte");
  a_priv_cause: assert property (
    priv_exc_out |-> $past(instr_valid_in && !busy_out && !supervisor_in))
    else $error("exception without problem-mode request");
  a_priv_blocks: assert property (
    priv_exc_out |-> !dec_valid_out && !busy_out)
    else $error("privileged op went ahead");
  a_problem_ok: assert property (
    dec_valid_out |-> !priv_exc_out && $past(instr_valid_in && !busy_out))
    else $error("decode without request");
  a_len_fmt: assert property (
    dec_valid_out |-> format_out <= 3'h4 && halfwords_out ==
      (format_out == 3'h0 ? 2'h1 : format_out == 3'h4 ? 2'h3 : 2'h2))
    else $error("length does not match format");
  a_fetch_step: assert property (
    dec_valid_out |-> next_fetch_addr_out ==
      {$past(instr_addr_in[AW-1:1]), 1'b0} + {halfwords_out, 1'b0})
    else $error("fetch advance wrong");
  a_rr_fields: assert property (
    dec_valid_out && format_out == 3'h0 |->
      first_operand_reg_out == $past(instr_in[39:36]) &&
      second_operand_reg_out == $past(instr_in[35:32]))
    else $error("register fields wrong");
  a_addr_follow: assert property (
    s_stor_dec |=> addr_valid_out)
    else $error("no address after storage decode");
  a_la_nomem: assert property (
    la_write_out |-> s_la_done)
    else $error("load address touched storage");
  a_walk_up: assert property (
    byte_valid_out && !byte_last_out |=> byte_valid_out &&
      byte_addr_out == $past(byte_addr_out) + 1'b1)
    else $error("byte walk not ascending");
endmodule // ifd_decoder_chk

bind ifd_decoder ifd_decoder_chk #(.AW(AW)) u_chk (.ref_clk_in, .rst_in,
  .instr_valid_in, .instr_in, .instr_addr_in, .supervisor_in, .busy_out,
  .dec_valid_out, .opcode_out, .format_out, .halfwords_out,
  .next_fetch_addr_out, .priv_exc_out, .first_operand_reg_out,
  .second_operand_reg_out, .addr_valid_out, .mem_access_out,
  .la_write_out, .byte_valid_out, .byte_addr_out, .byte_last_out);

/* File: ifd_gpr_model.sv */
/*
 General register file model answering base and index reads.
 Assumes the decoder reads it combinationally; register 0 is nonzero
 on purpose so a zero field that leaks register 0 shows up.
*/
`timescale 1ns/1ps

module ifd_gpr_model (
  input wire [3:0] base_reg_in,
  input wire [3:0] index_reg_in,
  output wire [31:0] base_data_out,
  output wire [31:0] index_data_out
);
  assign base_data_out = ({28'h0, base_reg_in} + 32'h1) * 32'h111;
  assign index_data_out = ({28'h0, index_reg_in} + 32'h1) * 32'h111;
endmodule // ifd_gpr_model

/* File: instruction_format_decoder_bench.sv */
/*
 Self-checking bench for ifd_decoder with a register file model.
 Assumes a 50 MHz clock and synchronous active-high reset.
*/
`timescale 1ns/1ps

module instruction_format_decoder_bench;
  localparam AW = 24;
  reg ref_clk_in = 1'b0;
  reg rst_in = 1'b1;
  reg instr_valid_in = 1'b0;
  reg [47:0] instr_in = 48'h0;
  reg [AW-1:0] instr_addr_in = 24'h000101;
  reg supervisor_in = 1'b0;
  reg [19:0] reloc_reg_in = 20'h0;
  reg reloc_en_in = 1'b0;
  wire [31:0] base_data_in, index_data_in, la_data_out;
  wire busy_out, dec_valid_out, fetch_align_err_out, priv_exc_out;
  wire mask_valid_out, imm_valid_out, addr_valid_out, mem_access_out;
  wire la_write_out, byte_valid_out, byte_last_out;
  wire [7:0] opcode_out, immediate_byte_field_out;
  wire [2:0] format_out;
  wire [1:0] halfwords_out;
  wire [AW-1:0] next_fetch_addr_out, addr_out, byte_addr_out;
  wire [3:0] first_operand_reg_out, second_operand_reg_out, la_reg_out;
  wire [3:0] branch_mask_field_out, index_reg_field_out;
  wire [3:0] base_reg_field_out, result_reg_out;
  wire [8:0] oper_len_out;
  wire fpr_sel_out, result_valid_out;
  wire [11:0] displacement_field_out;
  integer err_count = 0;
  integer cmp_count = 0;

  always #10 ref_clk_in = ~ref_clk_in;

  ifd_decoder #(.PRIV_OPS(256'h1 << 8'h80), .SI_OPS(64'h40000),
    .IMM_RR_OPS(64'h400), .FPR_OPS(64'h4000000)) u_dut (.ref_clk_in,
    .rst_in, .instr_valid_in,
    .instr_in, .instr_addr_in, .supervisor_in, .reloc_reg_in,
    .reloc_en_in, .base_data_in, .index_data_in, .busy_out,
    .dec_valid_out, .opcode_out, .format_out, .halfwords_out,
    .next_fetch_addr_out, .fetch_align_err_out, .priv_exc_out,
    .first_operand_reg_out, .second_operand_reg_out, .fpr_sel_out,
    .branch_mask_field_out, .mask_valid_out, .immediate_byte_field_out,
    .imm_valid_out, .index_reg_field_out, .base_reg_field_out,
    .displacement_field_out, .result_reg_out, .result_valid_out,
    .addr_valid_out, .addr_out, .mem_access_out, .la_write_out,
    .la_reg_out, .la_data_out, .byte_valid_out, .byte_addr_out,
    .byte_last_out, .oper_len_out);

  ifd_gpr_model u_gpr (.base_reg_in(base_reg_field_out),
    .index_reg_in(index_reg_field_out), .base_data_out(base_data_in),
    .index_data_out(index_data_in));

  //////////////////////////////////////////////////////////////////////
  task print_verdict;
    begin
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  task check(input string name, input logic [31:0] seen, exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
        err_count = err_count + 1;
        $display("BAD %0s exp %h seen %h", name, exp, seen);
      end
    end
  endtask

  // One request, taken at the second edge; outputs settled after it
  task run(input [47:0] ins, input sup);
    begin
      @(posedge ref_clk_in);
      instr_valid_in <= 1'b1;
      instr_in <= ins;
      supervisor_in <= sup;
      @(posedge ref_clk_in);
      instr_valid_in <= 1'b0;
      #1;
    end
  endtask

  task step;
    begin
      @(posedge ref_clk_in);
      #1;
    end
  endtask

  task wait_idle;
    integer i;
    begin
      i = 0;
      while (busy_out !== 1'b0 && i < 20)
      begin
        step;
        i = i + 1;
      end
      if (i == 20)
      begin
        err_count = err_count + 1;
        $display("BAD busy_out stuck");
        print_verdict;
      end
    end
  endtask

  //////////////////////////////////////////////////////////////////////
  task t_rr;
    begin
      run(48'h1A5600000000, 1'b0);
      check("dec_valid", dec_valid_out, 1'h1);
      check("opcode", opcode_out, 8'h1A);
      check("format", format_out, 3'h0);
      check("halfwords", halfwords_out, 2'h1);
      check("next_fetch", next_fetch_addr_out, 24'h000102);
      check("align_err", fetch_align_err_out, 1'h1);
      check("r1", first_operand_reg_out, 4'h5);
      check("r2", second_operand_reg_out, 4'h6);
      check("fpr_sel", fpr_sel_out, 1'h1);
      check("no_mask", mask_valid_out, 1'h0);
      check("no_result", result_valid_out, 1'h0);
      run(48'h07C300000000, 1'b0);
      check("mask_valid", mask_valid_out, 1'h1);
      check("mask", branch_mask_field_out, 4'hC);
      check("gpr_sel", fpr_sel_out, 1'h0);
      check("no_imm", imm_valid_out, 1'h0);
      run(48'h0A5A00000000, 1'b0);
      check("imm_valid", imm_valid_out, 1'h1);
      check("imm", immediate_byte_field_out, 8'h5A);
      $display("t_rr done");
    end
  endtask

  task t_rx;
    begin
      @(posedge ref_clk_in);
      reloc_en_in <= 1'b1;
      reloc_reg_in <= 20'h00ABC;
      run(48'h5A3001230000, 1'b1);
      check("format", format_out, 3'h1);
      check("halfwords", halfwords_out, 2'h2);
      check("result_reg", result_reg_out, 4'h3);
      check("result_valid", result_valid_out, 1'h1);
      check("disp", displacement_field_out, 12'h123);
      step;
      check("addr_valid", addr_valid_out, 1'h1);
      check("addr zero", addr_out, 24'h000BDF);
      check("mem", mem_access_out, 1'h1);
      wait_idle;
      run(48'h5A3251230000, 1'b1);
      step;
      check("addr", addr_out, 24'h001578);
      check("index_fld", index_reg_field_out, 4'h2);
      check("base_fld", base_reg_field_out, 4'h5);
      wait_idle;
      run(48'h413251230000, 1'b1);
      step;
      check("la_write", la_write_out, 1'h1);
      check("la_mem", mem_access_out, 1'h0);
      check("la_reg", la_reg_out, 4'h3);
      check("la_data", la_data_out, 32'h00001578);
      wait_idle;
      $display("t_rx done");
    end
  endtask

  task t_priv;
    begin
      run(48'h801230000000, 1'b0);
      check("priv_exc", priv_exc_out, 1'h1);
      check("dec_blocked", dec_valid_out, 1'h0);
      step;
      check("no_addr", addr_valid_out, 1'h0);
      run(48'h801230000000, 1'b1);
      check("sup_dec", dec_valid_out, 1'h1);
      check("sup_exc", priv_exc_out, 1'h0);
      check("rs_format", format_out, 3'h2);
      wait_idle;
      @(posedge ref_clk_in);
      reloc_en_in <= 1'b0;
      run(48'h92FF10100000, 1'b1);
      check("si_format", format_out, 3'h3);
      step;
      check("no_reloc", addr_out, 24'h000232);
      @(posedge ref_clk_in);
      reloc_en_in <= 1'b1;
      wait_idle;
      $display("t_priv done");
    end
  endtask

  task t_ss;
    integer i;
    begin
      run(48'hD20230100000, 1'b1);
      check("ss_format", format_out, 3'h4);
      check("ss_hw", halfwords_out, 2'h3);
      step;
      check("ss_addr", addr_out, 24'h000F10);
      check("ss_len", oper_len_out, 9'h003);
      for (i = 0; i < 3; i = i + 1)
      begin
        step;
        check("byte_valid", byte_valid_out, 1'h1);
        check("byte_addr", byte_addr_out, 24'h000F10 + i);
        check("byte_last", byte_last_out, i == 2);
      end
      wait_idle;
      $display("t_ss done");
    end
  endtask

  // Reset in the middle of a long walk must stop it cleanly
  task t_reset;
    begin
      run(48'hD2FF30100000, 1'b1);
      step;
      step;
      check("walk_busy", busy_out, 1'h1);
      @(posedge ref_clk_in);
      rst_in <= 1'b1;
      @(posedge ref_clk_in);
      rst_in <= 1'b0;
      #1;
      check("rst_busy", busy_out, 1'h0);
      check("rst_byte", byte_valid_out, 1'h0);
      check("rst_opcode", opcode_out, 8'h00);
      run(48'h1A5600000000, 1'b0);
      check("rst_dec", dec_valid_out, 1'h1);
      $display("t_reset done");
    end
  endtask

  initial
  begin
    repeat (10) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    t_rr;
    t_rx;
    t_priv;
    t_ss;
    t_reset;
    print_verdict;
  end
endmodule // instruction_format_decoder_bench
